// ===== logic/trc_pkg.sv
// Package for the touch reset, calibration and acquisition-mode controller.
// Assumes a single 100 MHz clock and a plain strobe-based register port.
package trc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned RESET_READY_MS = 90;
  localparam int unsigned SOFT_RESET_MS  = 250;
  localparam int unsigned CHG_FLOAT_MS   = 100;
  localparam int unsigned MS_CYC         = CLK_MHZ * 1000;
  localparam int unsigned READY_CYC      = RESET_READY_MS * MS_CYC;
  localparam int unsigned SOFT_CYC       = SOFT_RESET_MS * MS_CYC;
  localparam int unsigned FLOAT_CYC      = CHG_FLOAT_MS * MS_CYC;

  // ==========================================================
  // Register offsets (bytes)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_MSG       = 8'h08;
  localparam logic [7:0] OFS_ACT_INT   = 8'h0C;
  localparam logic [7:0] OFS_IDLE_INT  = 8'h10;
  localparam logic [7:0] OFS_ACT2IDLE  = 8'h14;
  localparam logic [7:0] OFS_AUTORECAL = 8'h18;
  localparam logic [7:0] OFS_OBJ_EN    = 8'h1C;
  localparam logic [7:0] OFS_CHAN_EN   = 8'h20;

  // Field positions
  localparam int unsigned CTRL_SOFT_RST = 0;
  localparam int unsigned CTRL_RECAL    = 1;
  localparam int unsigned CTRL_DEEP     = 2;
  localparam int unsigned MSG_RESET     = 0;
  localparam int unsigned MSG_CFG_ERR   = 1;
  localparam int unsigned MSG_CAL_BEGIN = 2;
  localparam int unsigned MSG_CAL_END   = 3;

  // Reset values
  localparam logic [7:0]  ACT_INT_RST   = 8'h10;
  localparam logic [7:0]  IDLE_INT_RST  = 8'h40;
  localparam logic [15:0] ACT2IDLE_RST  = 16'h0BB8;
  localparam logic [15:0] AUTORECAL_RST = 16'h0000;

  // Sense line map
  localparam int unsigned X_PER_SLAVE = 11;
  localparam int unsigned Y_PER_SLAVE = 14;

  // ==========================================================
  // Types
  typedef enum logic [5:0] {
    ST_BOOT  = 6'b000001,
    ST_CAL   = 6'b000010,
    ST_SLEEP = 6'b000100,
    ST_BURST = 6'b001000,
    ST_DEEP  = 6'b010000,
    ST_IDLEX = 6'b100000
  } trc_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wr;
    logic        rd;
  } trc_bus_req_t;

  typedef struct packed {
    logic [1:0] slave;
    logic [3:0] idx;
  } trc_line_t;

endpackage

// ===== logic/trc_reset_ctrl.sv
// Start-up, reset, calibration and burst/sleep control of the touch controller.
// Assumes acquisition engine signals share clk; reset pin arrives asynchronously.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps

module trc_reset_ctrl
  import trc_pkg::*;
#(
  parameter int unsigned READY_CYCLES = trc_pkg::READY_CYC,
  parameter int unsigned SOFT_CYCLES  = trc_pkg::SOFT_CYC,
  parameter int unsigned FLOAT_CYCLES = trc_pkg::FLOAT_CYC,
  parameter int unsigned MS_CYCLES    = trc_pkg::MS_CYC,
  parameter int unsigned CHAN_GROUPS  = 16,
  parameter int unsigned OBJECTS      = 8
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Reset pin from host, asynchronous
  input  wire logic                   resetPinN,
  // Register port
  input  wire trc_pkg::trc_bus_req_t  busReq,
  output logic [31:0]                 rdData,
  // Change-notify open-drain pin
  output logic                        changeNotifyOut,
  output logic                        changeNotifyOe,
  // Configuration checksum
  input  wire logic [15:0]            cfgSum,
  input  wire logic [15:0]            storedSum,
  // Acquisition engine
  input  wire logic                   touchDetect,
  input  wire logic                   antiTouch,
  input  wire logic                   otherTouch,
  input  wire logic                   burstDone,
  input  wire logic                   calDone,
  output logic                        burstEn,
  output logic                        calStart,
  output logic [CHAN_GROUPS-1:0]      calMask,
  output logic [CHAN_GROUPS-1:0]      chanEnable,
  output logic [OBJECTS-1:0]          objEnable,
  output logic                        activeMode,
  output logic                        hostReady,
  // Sense line map
  input  wire logic [5:0]             lineX,
  input  wire logic [5:0]             lineY,
  output trc_pkg::trc_line_t          mapX,
  output trc_pkg::trc_line_t          mapY
);
  import trc_pkg::*;

  // ==========================================================
  // Reset pin synchroniser
  // A pulse shorter than a clock period may be missed; host must
  // hold the pin low across at least one rising edge.
  logic rstPinMeta;
  logic rstPinSync;
  logic rstAll;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstPinMeta <= 1'b1;
      rstPinSync <= 1'b1;
    end else begin
      rstPinMeta <= resetPinN;
      rstPinSync <= rstPinMeta;
    end
  end

  assign rstAll = sys_rst | ~rstPinSync;

  // ==========================================================
  // Register file
  trc_state_t            state;
  logic                  softMode;
  logic [25:0]           bootCnt;
  logic [25:0]           bootLimit;
  logic [7:0]            actInt;
  logic [7:0]            idleInt;
  logic [15:0]           act2Idle;
  logic [15:0]           autoRecal;
  logic                  deepSleep;
  logic                  softCmd;
  logic                  recalCmd;
  logic [3:0]            msgFlags;
  logic                  wrOk;
  logic                  rdOk;

  assign wrOk = busReq.wr & hostReady;
  assign rdOk = busReq.rd & hostReady;

  always_ff @(posedge clk) begin
    if (rstAll) begin
      actInt     <= ACT_INT_RST;
      idleInt    <= IDLE_INT_RST;
      act2Idle   <= ACT2IDLE_RST;
      autoRecal  <= AUTORECAL_RST;
      deepSleep  <= 1'b0;
      objEnable  <= '0;
      chanEnable <= '0;
      softCmd    <= 1'b0;
      recalCmd   <= 1'b0;
    end else begin
      softCmd  <= wrOk && busReq.addr == OFS_CTRL && busReq.wrData[CTRL_SOFT_RST];
      recalCmd <= wrOk && busReq.addr == OFS_CTRL && busReq.wrData[CTRL_RECAL];
      if (wrOk) begin
        case (busReq.addr)
          OFS_CTRL:      deepSleep  <= busReq.wrData[CTRL_DEEP];
          OFS_ACT_INT:   actInt     <= busReq.wrData[7:0];
          OFS_IDLE_INT:  idleInt    <= busReq.wrData[7:0];
          OFS_ACT2IDLE:  act2Idle   <= busReq.wrData[15:0];
          OFS_AUTORECAL: autoRecal  <= busReq.wrData[15:0];
          OFS_OBJ_EN:    objEnable  <= busReq.wrData[OBJECTS-1:0];
          OFS_CHAN_EN:   chanEnable <= busReq.wrData[CHAN_GROUPS-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rstAll) begin
      rdData <= '0;
    end else if (rdOk) begin
      case (busReq.addr)
        OFS_CTRL:      rdData <= {29'h0, deepSleep, 2'b00};
        OFS_STATUS:    rdData <= {26'h0, state};
        OFS_MSG:       rdData <= {28'h0, msgFlags};
        OFS_ACT_INT:   rdData <= {24'h0, actInt};
        OFS_IDLE_INT:  rdData <= {24'h0, idleInt};
        OFS_ACT2IDLE:  rdData <= {16'h0, act2Idle};
        OFS_AUTORECAL: rdData <= {16'h0, autoRecal};
        OFS_OBJ_EN:    rdData <= 32'(objEnable);
        OFS_CHAN_EN:   rdData <= 32'(chanEnable);
        default:       rdData <= 32'h0000_0000;
      endcase
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Millisecond tick and mode timers
  logic [16:0] msCnt;
  logic        msTick;
  logic [7:0]  sleepMs;
  logic [15:0] noTouchMs;
  logic [15:0] detectMs;

  always_ff @(posedge clk) begin
    if (rstAll || msTick) begin
      msCnt <= '0;
    end else begin
      msCnt <= msCnt + 17'h00001;
    end
  end

  assign msTick = (msCnt == 17'(MS_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rstAll || state != ST_SLEEP) begin
      sleepMs <= '0;
    end else if (msTick && sleepMs != 8'hFF) begin
      sleepMs <= sleepMs + 8'h01;
    end
  end

  // Active/idle mode selection
  always_ff @(posedge clk) begin
    if (rstAll) begin
      activeMode <= 1'b0;
      noTouchMs  <= '0;
    end else if (touchDetect) begin
      activeMode <= 1'b1;
      noTouchMs  <= '0;
    end else begin
      if (msTick && noTouchMs != 16'hFFFF) begin
        noTouchMs <= noTouchMs + 16'h0001;
      end
      if (noTouchMs >= act2Idle) begin
        activeMode <= 1'b0;
      end
    end
  end

  // Time spent continuously in detect
  always_ff @(posedge clk) begin
    if (rstAll || !touchDetect || state == ST_CAL) begin
      detectMs <= '0;
    end else if (msTick && detectMs != 16'hFFFF) begin
      detectMs <= detectMs + 16'h0001;
    end
  end

  // ==========================================================
  // Calibration triggers
  logic [CHAN_GROUPS-1:0] chanPrev;
  logic                   calReq;
  logic                   running;
  logic                   trigEnable;
  logic                   trigHold;
  logic                   trigAnti;

  assign running    = (state == ST_SLEEP) || (state == ST_BURST) || (state == ST_DEEP);
  assign trigEnable = |(chanEnable & ~chanPrev);
  assign trigHold   = touchDetect && autoRecal != 16'h0000 && detectMs >= autoRecal;
  assign trigAnti   = antiTouch && !otherTouch;

  always_ff @(posedge clk) begin
    if (rstAll) begin
      chanPrev <= '0;
    end else begin
      chanPrev <= chanEnable;
    end
  end

  // Triggers are not taken in calibration, so its clear always wins
  always_ff @(posedge clk) begin
    if (rstAll) begin
      calReq <= 1'b0;
    end else if (running && (trigEnable || trigHold || trigAnti || recalCmd)) begin
      calReq <= 1'b1;
    end else if (state == ST_CAL) begin
      calReq <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  assign bootLimit = softMode ? 26'(SOFT_CYCLES - 1) : 26'(READY_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rstAll) begin
      state    <= ST_BOOT;
      softMode <= 1'b0;
      bootCnt  <= '0;
      burstEn  <= 1'b0;
      calStart <= 1'b0;
      calMask  <= '0;
    end else begin
      calStart <= 1'b0;
      calMask  <= '0;
      if (softCmd && state != ST_BOOT) begin
        state    <= ST_BOOT;
        softMode <= 1'b1;
        bootCnt  <= '0;
        burstEn  <= 1'b0;
      end else begin
        case (state)
          ST_BOOT: begin
            bootCnt <= bootCnt + 26'h0000001;
            if (bootCnt == bootLimit) begin
              state    <= ST_CAL;
              calStart <= 1'b1;
              calMask  <= '1;
            end
          end
          ST_CAL: begin
            if (calDone) begin
              state <= deepSleep ? ST_DEEP : ST_SLEEP;
            end
          end
          ST_SLEEP: begin
            if (calReq) begin
              state    <= ST_CAL;
              calStart <= 1'b1;
              calMask  <= '1;
            end else if (deepSleep) begin
              state <= ST_DEEP;
            end else if (sleepMs >= (activeMode ? actInt : idleInt)) begin
              state   <= ST_BURST;
              burstEn <= 1'b1;
            end
          end
          ST_BURST: begin
            if (burstDone) begin
              state   <= ST_SLEEP;
              burstEn <= 1'b0;
            end
          end
          ST_DEEP: begin
            if (!deepSleep) begin
              state <= ST_SLEEP;
            end
          end
          default: begin
            state   <= ST_BOOT;
            burstEn <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rstAll) begin
      hostReady <= 1'b0;
    end else begin
      hostReady <= (state != ST_BOOT) && !softCmd;
    end
  end

  // ==========================================================
  // Checksum and messages
  logic bootEnd;
  logic msgRead;
  logic [3:0] msgSet;

  assign bootEnd = (state == ST_BOOT) && (bootCnt == bootLimit) && !softCmd;
  assign msgRead = rdOk && busReq.addr == OFS_MSG;
  assign msgSet  = {(state == ST_CAL) && calDone,
                    calStart,
                    bootEnd && (cfgSum != storedSum),
                    bootEnd};

  // Reading the message register clears it; a same-cycle event survives
  always_ff @(posedge clk) begin
    if (rstAll) begin
      msgFlags <= '0;
    end else begin
      msgFlags <= (msgRead ? 4'h0 : msgFlags) | msgSet;
    end
  end

  // ==========================================================
  // Change-notify pin
  logic [26:0] floatCnt;
  logic        floatDone;

  assign floatDone = (floatCnt == 27'(FLOAT_CYCLES));

  always_ff @(posedge clk) begin
    if (rstAll || (softCmd && state != ST_BOOT)) begin
      floatCnt <= '0;
    end else if (!floatDone) begin
      floatCnt <= floatCnt + 27'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rstAll) begin
      changeNotifyOut <= 1'b0;
      changeNotifyOe  <= 1'b0;
    end else begin
      changeNotifyOut <= 1'b0;
      changeNotifyOe  <= floatDone && (|msgFlags);
    end
  end

  // ==========================================================
  // Sense line map, one instance per axis
  // Lines past the last slave fold into slave C; callers must stay in range.
  function automatic trc_line_t mapLine(input logic [5:0] line, input logic [5:0] per);
    trc_line_t m;
    m = '0;
    if (line < per) begin
      m.slave = 2'd0;
      m.idx   = line[3:0];
    end else if (line < 6'(2 * per)) begin
      m.slave = 2'd1;
      m.idx   = 4'(line - per);
    end else begin
      m.slave = 2'd2;
      m.idx   = 4'(line - 6'(2 * per));
    end
    return m;
  endfunction

  always_ff @(posedge clk) begin
    if (rstAll) begin
      mapX <= '0;
      mapY <= '0;
    end else begin
      mapX <= mapLine(lineX, 6'(X_PER_SLAVE));
      mapY <= mapLine(lineY, 6'(Y_PER_SLAVE));
    end
  end

  // ==========================================================
  // Assertions
  a_boot_hold: assert property (@(posedge clk) disable iff (rstAll)
    (state == ST_BOOT && bootCnt != bootLimit && !softCmd) |=> state == ST_BOOT)
    else $error("boot ended early");

  a_bus_blocked: assert property (@(posedge clk) disable iff (rstAll)
    (busReq.wr && !hostReady) |=> actInt == $past(actInt))
    else $error("write taken before ready");

  a_chg_float: assert property (@(posedge clk) disable iff (rstAll)
    !floatDone |=> !changeNotifyOe)
    else $error("change line driven during float");

  a_chg_msg: assert property (@(posedge clk) disable iff (rstAll)
    (floatDone && msgFlags != 4'h0) |=> changeNotifyOe)
    else $error("pending message not signalled");

  a_reset_flag: assert property (@(posedge clk) disable iff (rstAll)
    bootEnd |=> msgFlags[MSG_RESET] && state == ST_CAL)
    else $error("reset flag missing");

  a_cal_global: assert property (@(posedge clk) disable iff (rstAll)
    (state != ST_CAL ##1 state == ST_CAL) |-> calStart && calMask == '1)
    else $error("calibration not global");

  a_cal_msgs: assert property (@(posedge clk) disable iff (rstAll)
    (state == ST_CAL && calDone && !softCmd) |=> msgFlags[MSG_CAL_END])
    else $error("calibration end message missing");

  a_anti_recal: assert property (@(posedge clk) disable iff (rstAll)
    (running && trigAnti) |=> calReq)
    else $error("anti-touch did not request calibration");

  a_recal_taken: assert property (@(posedge clk) disable iff (rstAll)
    (state == ST_SLEEP && calReq && !softCmd) |=> state == ST_CAL && calStart)
    else $error("pending calibration not started");

  a_cfg_error: assert property (@(posedge clk) disable iff (rstAll)
    (bootEnd && cfgSum != storedSum) |=> msgFlags[MSG_CFG_ERR])
    else $error("checksum error not flagged");

  a_idle_switch: assert property (@(posedge clk) disable iff (rstAll)
    (!touchDetect && noTouchMs >= act2Idle) |=> !activeMode)
    else $error("idle switch missed");

  a_line_map: assert property (@(posedge clk) disable iff (rstAll)
    (lineX == 6'd22) |=> mapX.slave == 2'd2 && mapX.idx == 4'd0)
    else $error("X line map wrong");

endmodule

// ===== testbench/trc_host_model.sv
// Host side of the reset pin and the change-notify line.
// Assumes the design drives the line open-drain; a pull-up sits on the wire.
`timescale 1ns/1ps

module trc_host_model (
  // Clock
  input  wire logic clk,
  // Change-notify pin from the design
  input  wire logic changeNotifyOut,
  input  wire logic changeNotifyOe,
  // Bench request for a reset pulse
  input  wire logic pulseReq,
  // Pins
  output logic      resetPinN,
  output wire logic chgLine
);
  logic [3:0] rampCnt;
  logic [3:0] lowCnt;

  initial begin
    rampCnt   = 4'h0;
    lowCnt    = 4'h0;
    resetPinN = 1'b0;
  end

  // ==========================================================
  // Reset pin: low while supplies ramp, then short host pulses
  // Supplies are nominal before release, so no deep-sleep recovery is needed
  always @(posedge clk) begin
    if (rampCnt != 4'h4) begin
      rampCnt <= rampCnt + 4'h1;
    end
    if (pulseReq) begin
      lowCnt <= 4'h4;
    end else if (lowCnt != 4'h0) begin
      lowCnt <= lowCnt - 4'h1;
    end
    resetPinN <= (rampCnt == 4'h4) && (lowCnt == 4'h0) && !pulseReq;
  end

  // ==========================================================
  // Line resolution: host never drives it, pull-up wins when released
  assign chgLine = changeNotifyOe ? changeNotifyOut : 1'b1;
endmodule

// ===== testbench/trc_reset_ctrl_tb.sv
// Self-checking bench for the reset, calibration and mode controller.
// Assumes shortened counts via parameters and a one-cycle acquisition engine.
`timescale 1ns/1ps

module trc_reset_ctrl_tb;
  import trc_pkg::*;
  localparam int unsigned RDY = 200;
  localparam int unsigned SFT = 400;
  localparam int unsigned FLT = 300;
  localparam int unsigned MSC = 10;
  localparam int          LIMIT = 20000;

  logic clk = 1'b0, sys_rst = 1'b1, pulseReq = 1'b0, resetPinN, chgLine;
  trc_bus_req_t busReq = '0;
  logic [31:0] rdData;
  logic changeNotifyOut, changeNotifyOe, burstEn, calStart, activeMode, hostReady;
  logic touchDetect = 1'b0, antiTouch = 1'b0, otherTouch = 1'b0;
  logic burstDone = 1'b0, calDone = 1'b0;
  logic [15:0] cfgSum = 16'h1234, storedSum = 16'h4321;
  logic [15:0] calMask, chanEnable;
  logic [7:0]  objEnable;
  logic [5:0]  lineX = 6'h00, lineY = 6'h00;
  trc_line_t   mapX, mapY;
  int mismatches = 0, checks_done = 0, cycles = 0, n, i;
  logic [31:0] d;
  logic [7:0]  ofs [7] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30};
  logic [31:0] dflt [7] = '{32'h10, 32'h40, 32'hBB8, 32'h0, 32'h0, 32'h0, 32'h0};
  int          ln [6] = '{0, 10, 11, 21, 22, 32};
  int          ly [6] = '{0, 13, 14, 27, 28, 41};

  always #5 clk = ~clk;

  trc_reset_ctrl #(.READY_CYCLES(RDY), .SOFT_CYCLES(SFT), .FLOAT_CYCLES(FLT),
    .MS_CYCLES(MSC), .CHAN_GROUPS(16), .OBJECTS(8)) trc_reset_ctrl_i (
    .clk(clk), .sys_rst(sys_rst), .resetPinN(resetPinN), .busReq(busReq),
    .rdData(rdData), .changeNotifyOut(changeNotifyOut), .changeNotifyOe(changeNotifyOe),
    .cfgSum(cfgSum), .storedSum(storedSum), .touchDetect(touchDetect),
    .antiTouch(antiTouch), .otherTouch(otherTouch), .burstDone(burstDone),
    .calDone(calDone), .burstEn(burstEn), .calStart(calStart), .calMask(calMask),
    .chanEnable(chanEnable), .objEnable(objEnable), .activeMode(activeMode),
    .hostReady(hostReady), .lineX(lineX), .lineY(lineY), .mapX(mapX), .mapY(mapY));

  trc_host_model trc_host_model_i (.clk(clk), .changeNotifyOut(changeNotifyOut),
    .changeNotifyOe(changeNotifyOe), .pulseReq(pulseReq), .resetPinN(resetPinN),
    .chgLine(chgLine));

  // ==========================================================
  // Acquisition engine stand-in: answers one cycle late
  always @(posedge clk) begin
    calDone   <= calStart;
    burstDone <= burstEn && !burstDone;
  end

  // ==========================================================
  // Reporting
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got & m, exp & m);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Register port
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wrData: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    v = rdData;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = hostReady;
      1: pick = calStart;
      2: pick = activeMode;
      default: pick = burstEn;
    endcase
  endfunction

  // Waits for a settled level, bounded; the count of edges comes back
  task automatic wait_on(input int sel, input logic val, input int bound, output int cnt);
    cnt = 0;
    while (pick(sel) !== val && cnt < bound) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    cmp1(cnt < bound, 1'b1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (50) @(posedge clk);
    rd(OFS_STATUS, d); cmp32(d, 32'h0, 32'hFFFFFFFF);
    wait_on(0, 1'b1, RDY + 50, n);
    cmp1(n + 52 >= RDY - 1 && n + 52 <= RDY + 3, 1'b1);
    repeat (FLT - RDY - 30) @(posedge clk);
    #1 cmp1(chgLine, 1'b1);
    repeat (40) @(posedge clk);
    #1 cmp1(chgLine, 1'b0);
    rd(OFS_MSG, d); cmp32(d, 32'hF, 32'hF);
    cmp1(objEnable === 8'h00, 1'b1);
    for (i = 0; i < 7; i++) begin
      rd(ofs[i], d); cmp32(d, dflt[i], 32'hFFFFFFFF);
    end
    wr(OFS_ACT_INT, 32'h1);
    rd(OFS_ACT_INT, d); cmp32(d, 32'h1, 32'hFF);
    // Recalibrate command, global mask, begin and end messages
    wr(OFS_CTRL, 32'h2);
    wait_on(1, 1'b1, 2000, n);
    cmp32({16'h0, calMask}, 32'hFFFF, 32'hFFFF);
    repeat (3) @(posedge clk);
    rd(OFS_MSG, d); cmp32(d, 32'hC, 32'hC);
    // Channel enable, anti-touch and auto-recalibration triggers
    wr(OFS_CHAN_EN, 32'h1);
    wait_on(1, 1'b1, 2000, n);
    cmp32({16'h0, chanEnable}, 32'h1, 32'hFFFF);
    repeat (5) @(posedge clk);
    antiTouch <= 1'b1;
    wait_on(1, 1'b1, 2000, n);
    @(posedge clk) antiTouch <= 1'b0;
    wr(OFS_AUTORECAL, 32'h1);
    touchDetect <= 1'b1;
    wait_on(1, 1'b1, 2000, n);
    @(posedge clk) touchDetect <= 1'b0;
    wr(OFS_AUTORECAL, 32'h0);
    // Active and idle modes with burst cycles
    wr(OFS_ACT2IDLE, 32'h2);
    wait_on(2, 1'b0, 2000, n);
    wait_on(3, 1'b1, 2000, n);
    @(posedge clk) touchDetect <= 1'b1;
    wait_on(2, 1'b1, 2000, n);
    @(posedge clk) touchDetect <= 1'b0;
    // Deep sleep parks the sequencer until the host clears it
    wr(OFS_CTRL, 32'h4);
    repeat (4) @(posedge clk);
    rd(OFS_STATUS, d); cmp32(d, 32'h10, 32'h3F);
    rd(OFS_CTRL, d); cmp32(d, 32'h4, 32'h7);
    wr(OFS_CTRL, 32'h0);
    // Two objects enabled, object enable mask read back
    wr(OFS_OBJ_EN, 32'h3);
    rd(OFS_OBJ_EN, d); cmp32(d, 32'h3, 32'hFF);
    // Sense line mapping at slave boundaries; lines are used from the lowest up
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      lineX <= ln[i][5:0];
      lineY <= ly[i][5:0];
      repeat (2) @(posedge clk);
      #1 cmp32({26'h0, mapX}, (ln[i] / 11) * 16 + ln[i] % 11, 32'h3F);
      cmp32({26'h0, mapY}, (ly[i] / 14) * 16 + ly[i] % 14, 32'h3F);
    end
    // Software reset keeps configuration and flags a reset
    wr(OFS_CTRL, 32'h1);
    wait_on(0, 1'b0, 10, n);
    wait_on(0, 1'b1, SFT + 50, n);
    cmp1(n >= SFT - 5, 1'b1);
    rd(OFS_MSG, d); cmp32(d, 32'h1, 32'h1);
    rd(OFS_ACT_INT, d); cmp32(d, 32'h1, 32'hFF);
    // Pin reset is a full hardware reset
    @(posedge clk);
    pulseReq <= 1'b1;
    storedSum <= 16'h1234;
    @(posedge clk);
    pulseReq <= 1'b0;
    wait_on(0, 1'b0, 20, n);
    wait_on(0, 1'b1, RDY + 50, n);
    rd(OFS_ACT_INT, d); cmp32(d, 32'h10, 32'hFF);
    rd(OFS_MSG, d); cmp32(d, 32'h1, 32'h3);
    cmp1(objEnable === 8'h00, 1'b1);
    conclude();
  end
endmodule
